// ==== cpm_pkg.sv ====
package cpm_pkg;

  // ****************************************
  // Register offsets
  // ****************************************
  localparam logic [7:0] OFS_PIN_E = 8'h5a;
  localparam logic [7:0] OFS_RSV_5B = 8'h5b;
  localparam logic [7:0] OFS_RSV_5C = 8'h5c;
  localparam logic [7:0] OFS_RSV_5F = 8'h5f;
  localparam logic [7:0] OFS_SHARED = 8'h60;
  localparam logic [7:0] OFS_RSV_61 = 8'h61;
  localparam logic [7:0] OFS_RSV_63 = 8'h63;
  localparam logic [7:0] OFS_EDGE = 8'h64;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int E_FUNC_LSB = 2;
  localparam int E_LVL_BIT = 1;
  localparam int S_FUNC_LSB = 1;
  localparam int EDGE_M1L_BIT = 7;
  localparam int EDGE_M1R_BIT = 6;
  localparam int EDGE_M2L_BIT = 3;
  localparam int EDGE_M2R_BIT = 2;

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [4:0] E_FUNC_RST = 5'h00;
  localparam logic [3:0] S_FUNC_RST = 4'h1;
  localparam logic [3:0] EDGE_RST = 4'h5;

  // ****************************************
  // Function codes
  // ****************************************
  localparam logic [4:0] E_DISABLED = 5'h00;
  localparam logic [4:0] E_INPUT = 5'h01;
  localparam logic [4:0] E_MODCLK = 5'h0a;
  localparam logic [4:0] E_GP_OUT = 5'h0b;
  localparam logic [4:0] E_PORT_C_OUT = 5'h1d;
  localparam logic [3:0] S_DISABLED = 4'h0;
  localparam logic [3:0] S_READ_DATA = 4'h1;
  localparam logic [3:0] S_GP_OUT = 4'h2;
  localparam logic [3:0] S_CLK_OUT = 4'h3;
  localparam logic [3:0] S_IRQ_A = 4'h4;
  localparam logic [3:0] S_IRQ_B = 4'h5;
  localparam logic [3:0] S_SAR_IRQ = 4'h6;
  localparam logic [3:0] S_MODCLK = 4'h7;
  localparam logic [3:0] S_PAIR2 = 4'hd;
  localparam logic [3:0] S_PAIR3 = 4'he;
  localparam logic [3:0] SRC_PIN_E = 4'h4;

  // ****************************************
  // State carriers
  // ****************************************
  typedef struct packed {
    logic [4:0] e_func;
    logic e_gp;
    logic [3:0] s_func;
    logic s_gp;
    logic [3:0] edge_sel;
    logic [2:0] e_sync;
    logic e_lvl;
    logic [1:0] mclk_sync;
    logic [3:0] src_hit;
    logic e_out;
    logic e_oe;
    logic s_out;
    logic s_oe;
    logic [7:0] rdata;
    logic rvalid;
  } cpm_core_t;

  typedef struct packed {
    logic [8:0] s1;
    logic [8:0] s2;
    logic mclk;
    logic rise_smp;
    logic [3:0] mic;
    logic mic_valid;
  } cpm_link_t;

endpackage

// ==== cpm_pin_mux.sv ====
`timescale 1ns/100ps
module cpm_pin_mux (
  // Clocks and resets
  input wire logic clock,
  input wire logic rst,
  input wire logic mod_clk,
  input wire logic rst_link,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  output logic reg_rvalid,
  // Pin E
  input wire logic pin_e_in,
  output logic pin_e_out,
  output logic pin_e_oe,
  output logic pin_e_level,
  // Shared output pin
  output logic shared_out,
  output logic shared_oe,
  // Sources for the pins
  input wire logic spi_mode,
  input wire logic multi_pin_mode,
  input wire logic spi_read_data,
  input wire logic internal_clock_output,
  input wire logic irq_line_a,
  input wire logic irq_line_b,
  input wire logic sar_irq,
  input wire logic port_a_pair2_data,
  input wire logic port_a_pair3_data,
  input wire logic port_c_data_out,
  input wire logic [15:0] mic_src_sel,
  // Microphone samples, modulator clock domain
  output logic mic_mod_clock,
  output logic [3:0] mic_bits,
  output logic mic_valid
);

  cpm_pkg::cpm_core_t r;
  cpm_pkg::cpm_core_t r_nxt;
  cpm_pkg::cpm_link_t l;
  cpm_pkg::cpm_link_t l_nxt;

  // ****************************************
  // Register file and pin muxes
  // ****************************************
  always_comb begin
    r_nxt = r;
    r_nxt.rvalid = reg_rd;
    r_nxt.rdata = 8'h00;
    if (reg_wr) begin
      case (reg_addr)
        cpm_pkg::OFS_PIN_E: begin
          r_nxt.e_func = reg_wdata[cpm_pkg::E_FUNC_LSB +: 5];
          r_nxt.e_gp = reg_wdata[0];
        end
        cpm_pkg::OFS_SHARED: begin
          r_nxt.s_func = reg_wdata[cpm_pkg::S_FUNC_LSB +: 4];
          r_nxt.s_gp = reg_wdata[0];
        end
        cpm_pkg::OFS_EDGE: begin
          r_nxt.edge_sel = {reg_wdata[cpm_pkg::EDGE_M1L_BIT], reg_wdata[cpm_pkg::EDGE_M1R_BIT],
                            reg_wdata[cpm_pkg::EDGE_M2L_BIT], reg_wdata[cpm_pkg::EDGE_M2R_BIT]};
        end
        default: begin
        end
      endcase
    end
    if (reg_rd) begin
      case (reg_addr)
        cpm_pkg::OFS_PIN_E: r_nxt.rdata = {1'b0, r.e_func, r.e_lvl, r.e_gp};
        cpm_pkg::OFS_SHARED: r_nxt.rdata = {3'h0, r.s_func, r.s_gp};
        cpm_pkg::OFS_EDGE: r_nxt.rdata = {r.edge_sel[3:2], 2'h0, r.edge_sel[1:0], 2'h0};
        default: r_nxt.rdata = 8'h00;
      endcase
    end
    // Pin level filter: a change counts once stages two and three agree.
    r_nxt.e_sync = {r.e_sync[1:0], pin_e_in};
    if (r.e_sync[1] == r.e_sync[2]) begin
      r_nxt.e_lvl = r.e_sync[2];
    end
    r_nxt.mclk_sync = {r.mclk_sync[0], l.mclk};
    // channel takes pin E when its source code matches
    for (int i = 0; i < 4; i++) begin
      r_nxt.src_hit[i] = (mic_src_sel[4*i +: 4] == cpm_pkg::SRC_PIN_E);
    end
    r_nxt.e_out = 1'b0;
    r_nxt.e_oe = 1'b0;
    case (r.e_func)
      cpm_pkg::E_MODCLK: begin
        r_nxt.e_out = r.mclk_sync[1];
        r_nxt.e_oe = 1'b1;
      end
      cpm_pkg::E_GP_OUT: begin
        r_nxt.e_out = r.e_gp;
        r_nxt.e_oe = 1'b1;
      end
      cpm_pkg::E_PORT_C_OUT: begin
        r_nxt.e_out = port_c_data_out;
        r_nxt.e_oe = 1'b1;
      end
      default: begin
      end
    endcase
    r_nxt.s_out = 1'b0;
    r_nxt.s_oe = 1'b1;
    case (r.s_func)
      // read data only under SPI control
      cpm_pkg::S_READ_DATA: begin
        r_nxt.s_out = spi_read_data;
        r_nxt.s_oe = spi_mode;
      end
      cpm_pkg::S_GP_OUT: r_nxt.s_out = r.s_gp;
      cpm_pkg::S_CLK_OUT: r_nxt.s_out = internal_clock_output;
      cpm_pkg::S_IRQ_A: r_nxt.s_out = irq_line_a;
      cpm_pkg::S_IRQ_B: r_nxt.s_out = irq_line_b;
      cpm_pkg::S_SAR_IRQ: r_nxt.s_out = sar_irq;
      cpm_pkg::S_MODCLK: r_nxt.s_out = r.mclk_sync[1];
      cpm_pkg::S_PAIR2: begin
        r_nxt.s_out = port_a_pair2_data;
        r_nxt.s_oe = multi_pin_mode;
      end
      cpm_pkg::S_PAIR3: begin
        r_nxt.s_out = port_a_pair3_data;
        r_nxt.s_oe = multi_pin_mode;
      end
      // disabled and reserved codes release the pin
      default: r_nxt.s_oe = 1'b0;
    endcase
    if (rst) begin
      r_nxt = '0;
      r_nxt.e_func = cpm_pkg::E_FUNC_RST;
      r_nxt.s_func = cpm_pkg::S_FUNC_RST;
      r_nxt.edge_sel = cpm_pkg::EDGE_RST;
    end
  end

  always_ff @(posedge clock) begin
    r <= r_nxt;
  end

  assign reg_rdata = r.rdata;
  assign reg_rvalid = r.rvalid;
  assign pin_e_out = r.e_out;
  assign pin_e_oe = r.e_oe;
  assign pin_e_level = r.e_lvl;
  assign shared_out = r.s_out;
  assign shared_oe = r.s_oe;

  // ****************************************
  // Microphone capture on the modulator clock
  // ****************************************
  logic [3:0] l_edge;
  logic [3:0] l_hit;
  logic l_in_mode;

  assign l_edge = l.s2[8:5];
  assign l_hit = l.s2[4:1];
  assign l_in_mode = l.s2[0];

  always_comb begin
    l_nxt = l;
    l_nxt.s1 = {r.edge_sel, r.src_hit, r.e_func == cpm_pkg::E_INPUT};
    l_nxt.s2 = l.s1;
    l_nxt.mclk = ~l.mclk;
    l_nxt.mic_valid = 1'b0;
    if (!l.mclk) begin
      l_nxt.rise_smp = pin_e_in;
    end else begin
      l_nxt.mic_valid = 1'b1;
      for (int i = 0; i < 4; i++) begin
        l_nxt.mic[i] = l_hit[i] & l_in_mode & (l_edge[i] ? pin_e_in : l.rise_smp);
      end
    end
    if (rst_link) begin
      l_nxt = '0;
    end
  end

  always_ff @(posedge mod_clk) begin
    l <= l_nxt;
  end

  assign mic_mod_clock = l.mclk;
  assign mic_bits = l.mic;
  assign mic_valid = l.mic_valid;

  // ****************************************
  // Checks
  // ****************************************
  chk_e_release: assert property (@(posedge clock) disable iff (rst)
    (r.e_func == cpm_pkg::E_DISABLED || r.e_func == cpm_pkg::E_INPUT) |=> !pin_e_oe)
    else $error("pin E driven while disabled or input");

  chk_e_modclk: assert property (@(posedge clock) disable iff (rst)
    r.e_func == cpm_pkg::E_MODCLK |=> pin_e_oe && pin_e_out == $past(r.mclk_sync[1]))
    else $error("pin E not carrying modulator clock");

  chk_e_port_c: assert property (@(posedge clock) disable iff (rst)
    r.e_func == cpm_pkg::E_PORT_C_OUT |=> pin_e_oe && pin_e_out == $past(port_c_data_out))
    else $error("pin E not carrying port C data");

  chk_e_level_read: assert property (@(posedge clock) disable iff (rst)
    reg_rd && reg_addr == cpm_pkg::OFS_PIN_E |=> reg_rvalid && reg_rdata[1] == $past(r.e_lvl))
    else $error("pin E level not in read data");

  chk_edge_write: assert property (@(posedge clock) disable iff (rst)
    reg_wr && reg_addr == cpm_pkg::OFS_EDGE ##1 reg_rd && reg_addr == cpm_pkg::OFS_EDGE
    |=> reg_rdata == ($past(reg_wdata, 2) & 8'hcc))
    else $error("edge register readback wrong");

  chk_rsv_zero: assert property (@(posedge clock) disable iff (rst)
    reg_rd && reg_addr >= cpm_pkg::OFS_RSV_61 && reg_addr <= cpm_pkg::OFS_RSV_63 |=> reg_rdata == 8'h00)
    else $error("reserved register not zero");

  chk_s_spi_gate: assert property (@(posedge clock) disable iff (rst)
    r.s_func == cpm_pkg::S_READ_DATA |=> shared_oe == $past(spi_mode))
    else $error("read data drive ignores control mode");

  chk_s_irq_b: assert property (@(posedge clock) disable iff (rst)
    r.s_func == cpm_pkg::S_IRQ_B |=> shared_oe && shared_out == $past(irq_line_b))
    else $error("second interrupt not on shared pin");

  chk_s_multi: assert property (@(posedge clock) disable iff (rst)
    (r.s_func == cpm_pkg::S_PAIR2 || r.s_func == cpm_pkg::S_PAIR3) && !multi_pin_mode |=> !shared_oe)
    else $error("pair data driven outside multi-pin mode");

  chk_s_gp: assert property (@(posedge clock) disable iff (rst)
    r.s_func == cpm_pkg::S_GP_OUT |=> shared_oe && shared_out == $past(r.s_gp))
    else $error("shared pin level differs from D0");

  chk_reset_codes: assert property (@(posedge clock)
    rst |=> r.e_func == cpm_pkg::E_FUNC_RST && r.s_func == cpm_pkg::S_FUNC_RST && r.edge_sel == 4'h5)
    else $error("reset values wrong");

  chk_mic_rise: assert property (@(posedge mod_clk) disable iff (rst_link)
    l.mclk && l_hit[1] && l_in_mode && !l_edge[1] |=> mic_bits[1] == $past(l.rise_smp) && mic_valid)
    else $error("rising edge sample not latched");

  chk_mic_src: assert property (@(posedge mod_clk) disable iff (rst_link)
    l.mclk && !l_hit[0] |=> !mic_bits[0])
    else $error("channel latched from unselected source");

endmodule

// ==== cpm_mic_model.sv ====
`timescale 1ns/100ps
// ****************************************
// Microphone stand-in
// ****************************************
module cpm_mic_model (
  // Microphone clock
  input wire logic mic_clk,
  // Bench control
  input wire logic hold_en,
  input wire logic hold_val,
  // Data line and the pair of the last period
  output logic line,
  output logic [1:0] last_pair
);
  logic lo = 1'b0;
  logic hi = 1'b1;
  initial last_pair = 2'b00;
  // The line shows one bit while the clock is low and a fresh one while it is high.
  assign line = hold_en ? hold_val : (mic_clk ? hi : lo);
  always @(negedge mic_clk) begin
    #1 last_pair = {hi, lo};
    lo = 1'($urandom);
    hi = 1'($urandom);
  end
endmodule

// ==== cpm_pin_mux_bench.sv ====
`timescale 1ns/100ps
module cpm_pin_mux_bench;
  // ****************************************
  // Signals and instances
  // ****************************************
  logic clock = 0, rst = 1, mod_clk = 0, rst_link = 1;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
  logic reg_wr = 0, reg_rd = 0, reg_rvalid, gp;
  logic pin_e_in, pin_e_out, pin_e_oe, pin_e_level, shared_out, shared_oe;
  logic [9:0] src = 10'h000;
  logic [15:0] mic_src_sel = 16'h0000;
  logic mic_mod_clock, mic_valid, mic_line, hold_en = 1, hold_val = 0, mic_chk = 0, mic_on = 0;
  logic [3:0] mic_bits, edge_v = 4'h0, f;
  logic [4:0] c;
  logic [1:0] pair, e;
  logic [7:0] exp_q[$];
  logic [4:0] ecodes[5] = '{5'h00, 5'h01, 5'h0a, 5'h0b, 5'h1d};
  logic [3:0] scodes[10] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'hd, 4'he};
  logic [7:0] rsv[6] = '{8'h5b, 8'h5c, 8'h5f, 8'h61, 8'h63, 8'h70};
  int fails = 0, compares = 0;
  always #20 clock = ~clock;
  always #24 mod_clk = ~mod_clk;
  // The wire follows the block while it drives, the microphone otherwise.
  assign pin_e_in = pin_e_oe ? pin_e_out : mic_line;
  cpm_pin_mux i_dut (.clock(clock), .rst(rst), .mod_clk(mod_clk), .rst_link(rst_link), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .pin_e_in(pin_e_in), .pin_e_out(pin_e_out), .pin_e_oe(pin_e_oe), .pin_e_level(pin_e_level),
    .shared_out(shared_out), .shared_oe(shared_oe), .spi_mode(src[9]), .multi_pin_mode(src[8]),
    .spi_read_data(src[7]), .internal_clock_output(src[6]), .irq_line_a(src[5]), .irq_line_b(src[4]),
    .sar_irq(src[3]), .port_a_pair2_data(src[2]), .port_a_pair3_data(src[1]), .port_c_data_out(src[0]),
    .mic_src_sel(mic_src_sel), .mic_mod_clock(mic_mod_clock), .mic_bits(mic_bits), .mic_valid(mic_valid));
  cpm_mic_model i_mic (.mic_clk(mic_mod_clock), .hold_en(hold_en), .hold_val(hold_val), .line(mic_line),
    .last_pair(pair));
  // ****************************************
  // Tasks and watchers
  // ****************************************
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #2;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    tick(1);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1;
    tick(1);
    reg_wr = 0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] x);
    tick(1);
    reg_addr = a;
    reg_rd = 1;
    exp_q.push_back(x);
    tick(1);
    reg_rd = 0;
  endtask
  task automatic wr_rd(input logic [7:0] a, input logic [7:0] d, input logic [7:0] x);
    tick(1);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1;
    tick(1);
    reg_wr = 0;
    reg_rd = 1;
    exp_q.push_back(x);
    tick(1);
    reg_rd = 0;
  endtask
  task automatic tally_and_finish();
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  function automatic logic [1:0] sh_exp();
    case (f)
      4'h1: return {src[9], src[7]};
      4'h2: return {1'b1, gp};
      4'h3: return {1'b1, src[6]};
      4'h4: return {1'b1, src[5]};
      4'h5: return {1'b1, src[4]};
      4'h6: return {1'b1, src[3]};
      4'h7: return 2'b10;
      4'hd: return {src[8], src[2]};
      4'he: return {src[8], src[1]};
      default: return 2'b00;
    endcase
  endfunction
  always @(negedge clock) begin
    if (reg_rvalid === 1'b1) begin
      chk(reg_rdata, exp_q.pop_front());
    end
  end
  always @(negedge mod_clk) begin
    if (mic_chk && mic_valid === 1'b1) begin
      for (int i = 0; i < 4; i++) begin
        chk(mic_bits[i], mic_on & (edge_v[i] ? pair[1] : pair[0]));
      end
    end
  end
  initial begin
    #400000;
    fails++;
    tally_and_finish();
  end
  // ****************************************
  // Scenarios
  // ****************************************
  initial begin
    void'($urandom(32'hbd7c1bdc));
    tick(20);
    rst = 0;
    rst_link = 0;
    rd(cpm_pkg::OFS_PIN_E, 8'h00);
    rd(cpm_pkg::OFS_SHARED, 8'h02);
    rd(cpm_pkg::OFS_EDGE, 8'h44);
    foreach (rsv[i]) rd(rsv[i], 8'h00);
    wr_rd(cpm_pkg::OFS_EDGE, 8'hcc, 8'hcc);
    hold_val = 1;
    tick(6);
    rd(cpm_pkg::OFS_PIN_E, 8'h02);
    for (int k = 0; k < 10; k++) begin
      c = ecodes[k % 5];
      gp = 1'($urandom);
      src = 10'($urandom);
      wr(cpm_pkg::OFS_PIN_E, {1'b0, c, 1'b0, gp});
      tick(5);
      chk(pin_e_oe, c > 5'h01);
      if (c == 5'h0b) chk(pin_e_out, gp);
      if (c == 5'h1d) chk(pin_e_out, src[0]);
      if (c < 5'h02) rd(cpm_pkg::OFS_PIN_E, {1'b0, c, 1'b1, gp});
    end
    for (int k = 0; k < 20; k++) begin
      f = scodes[k % 10];
      gp = 1'($urandom);
      src = 10'($urandom);
      wr(cpm_pkg::OFS_SHARED, {3'b000, f, gp});
      tick(3);
      e = sh_exp();
      chk(shared_oe, e[1]);
      if (e[1] && f != 4'h7) chk(shared_out, e[0]);
      rd(cpm_pkg::OFS_SHARED, {3'b000, f, gp});
    end
    hold_en = 0;
    for (int k = 0; k < 6; k++) begin
      mic_chk = 0;
      mic_on = k < 4;
      edge_v = 4'($urandom);
      mic_src_sel = (k == 4) ? 16'h3333 : 16'h4444;
      wr(cpm_pkg::OFS_PIN_E, (k == 5) ? 8'h00 : 8'h04);
      wr(cpm_pkg::OFS_EDGE, {edge_v[3:2], 2'b00, edge_v[1:0], 2'b00});
      tick(12);
      mic_chk = 1;
      tick(40);
    end
    mic_chk = 0;
    tally_and_finish();
  end
endmodule
